// ---- inc/rfb_pkg.sv ----
// rf data buffer and averaging-filter lock package: register map, field layout, resets
// assumes a 32-bit axi4-lite slave with one register per aligned word
package rfb_pkg;
  // register byte addresses (data buffer offset is the printed one)
  localparam logic [7:0] RFB_OFS_DATA   = 8'hc9;
  localparam logic [7:0] RFB_IDX_DATA   = 8'hc9;
  localparam logic [11:0] RFB_ADDR_DATA = 12'h324;
  localparam logic [11:0] RFB_ADDR_CTRL = 12'h400;
  localparam logic [11:0] RFB_ADDR_AVG  = 12'h404;
  localparam logic [11:0] RFB_ADDR_STAT = 12'h408;
  localparam logic [11:0] RFB_ADDR_BAUD = 12'h40c;
  // control register fields
  localparam int RFB_CTRL_BYTEMODE = 0;
  localparam int RFB_CTRL_TRANSMITTER_POWERDOWN    = 1;
  localparam int RFB_CTRL_RECEIVER_POWERDOWN    = 2;
  localparam int RFB_CTRL_MANCH    = 3;
  localparam int RFB_CTRL_MDM_RSTN = 4;
  localparam logic [4:0] RFB_CTRL_RST = 5'h16;
  // average-filter control fields
  localparam int RFB_AVG_MANUAL  = 0;
  localparam int RFB_AVG_SELECT  = 1;
  localparam int RFB_AVG_SETL_LO = 2;
  localparam logic [3:0] RFB_AVG_RST = 4'he;
  // status fields
  localparam int RFB_STAT_IRQ    = 0;
  localparam int RFB_STAT_FROZEN = 1;
  localparam logic [15:0] RFB_BAUD_RST = 16'h0010;
  localparam logic [1:0] RFB_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RFB_RESP_SLVERR = 2'h2;
  // automatic freeze delay per settling code, in baud periods
  localparam logic [6:0] RFB_SETTLE_0 = 7'd11;
  localparam logic [6:0] RFB_SETTLE_1 = 7'd22;
  localparam logic [6:0] RFB_SETTLE_2 = 7'd43;
  localparam logic [6:0] RFB_SETTLE_3 = 7'd86;
  localparam int RFB_AVG_W = 12;

  // listed msb first so the fields sit at their RFB_CTRL_* positions
  typedef struct packed {
    logic       mdm_rstn;
    logic       manch;
    logic       receiver_powerdown;
    logic       transmitter_powerdown;
    logic       bytemode;
  } rfb_ctrl_t;

  typedef struct packed {
    logic [1:0] settling;
    logic       select;
    logic       manual;
  } rfb_avg_t;
endpackage

// ---- hw/rfb_top.sv ----
// rf data buffer, shift register and averaging-filter freeze control
// assumes axi4-lite on mclk_in; demodulator samples arrive as async pins
`timescale 1ns/100ps
`default_nettype none
module rfb_top
  import rfb_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input  wire logic                 mclk_in,
  input  wire logic                 rstn_in,
  input  wire logic [11:0]          s_axi_awaddr_in,
  input  wire logic                 s_axi_awvalid_in,
  output logic                      s_axi_awready_out,
  input  wire logic [31:0]          s_axi_wdata_in,
  input  wire logic [3:0]           s_axi_wstrb_in,
  input  wire logic                 s_axi_wvalid_in,
  output logic                      s_axi_wready_out,
  output logic [1:0]                s_axi_bresp_out,
  output logic                      s_axi_bvalid_out,
  input  wire logic                 s_axi_bready_in,
  input  wire logic [11:0]          s_axi_araddr_in,
  input  wire logic                 s_axi_arvalid_in,
  output logic                      s_axi_arready_out,
  output logic [31:0]               s_axi_rdata_out,
  output logic [1:0]                s_axi_rresp_out,
  output logic                      s_axi_rvalid_out,
  input  wire logic                 s_axi_rready_in,
  input  wire logic [RFB_AVG_W-1:0] data_filter_in,
  output logic                      tx_bit_out,
  output logic                      radio_irq_flag_out,
  output logic                      rx_bit_out
);
  logic rst_s1_q, rst_n;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // demodulator filter output crosses in through two stages
  logic [RFB_AVG_W-1:0] dfil_s1_q, dfil_q;
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      dfil_s1_q <= '0;
      dfil_q    <= '0;
    end else begin
      dfil_s1_q <= data_filter_in;
      dfil_q    <= dfil_s1_q;
    end
  end

  // registers
  rfb_ctrl_t         ctrl_q;
  rfb_avg_t          avg_q;
  logic [DATA_W-1:0] buf_q;
  logic [15:0]       baud_div_q;
  logic              irq_q;

  // write channel: address and data taken in either order
  // readies are registered and only high while the matching holding slot is free,
  // so an item is taken exactly at the edge where valid and ready are both high
  logic        aw_full_q, w_full_q, bvalid_q, awready_q, wready_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q;
  wire aw_take  = s_axi_awvalid_in && awready_q;
  wire w_take   = s_axi_wvalid_in && wready_q;
  wire wr_fire  = aw_full_q && w_full_q && !bvalid_q;
  // next-state views of the slots, used to decide the readies one edge ahead
  wire aw_full_d = (aw_full_q || aw_take) && !wr_fire;
  wire w_full_d  = (w_full_q || w_take) && !wr_fire;
  wire bvalid_d  = wr_fire || (bvalid_q && !s_axi_bready_in);
  wire wr_data  = wr_fire && awaddr_q == RFB_ADDR_DATA && wstrb_q[0];
  wire wr_ctrl  = wr_fire && awaddr_q == RFB_ADDR_CTRL && wstrb_q[0];
  wire wr_avg   = wr_fire && awaddr_q == RFB_ADDR_AVG && wstrb_q[0];
  wire wr_stat  = wr_fire && awaddr_q == RFB_ADDR_STAT && wstrb_q[0];
  wire wr_baud  = wr_fire && awaddr_q == RFB_ADDR_BAUD;
  wire wr_hit   = awaddr_q == RFB_ADDR_DATA || awaddr_q == RFB_ADDR_CTRL
               || awaddr_q == RFB_ADDR_AVG || awaddr_q == RFB_ADDR_STAT
               || awaddr_q == RFB_ADDR_BAUD;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bresp_q   <= RFB_RESP_OKAY;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
    end else begin
      // a new write is only accepted once the previous answer has gone
      awready_q <= !aw_full_d && !bvalid_d;
      wready_q  <= !w_full_d && !bvalid_d;
      if (aw_take) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_in;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata_in;
        wstrb_q  <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? RFB_RESP_OKAY : RFB_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // modem reset from software clears the datapath as the main reset does
  wire mdm_clr = !ctrl_q.mdm_rstn;

  // baud timing: one baud tick per baud_div_q+1 clocks; a bit is two bauds in manchester
  logic [15:0] baud_cnt_q;
  logic        half_q;
  wire baud_tick = baud_cnt_q == 16'h0000;
  wire bit_tick  = baud_tick && (!ctrl_q.manch || half_q);
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      baud_cnt_q <= '0;
      half_q     <= 1'b0;
    end else if (mdm_clr || (ctrl_q.transmitter_powerdown && ctrl_q.receiver_powerdown)) begin
      baud_cnt_q <= baud_div_q;
      half_q     <= 1'b0;
    end else begin
      baud_cnt_q <= baud_tick ? baud_div_q : baud_cnt_q - 16'h0001;
      if (baud_tick) half_q <= !half_q;
    end
  end

  // averaging filter, freeze control and slicer
  logic [RFB_AVG_W-1:0] avg_val_q;
  logic [6:0]           settle_cnt_q;
  logic                 auto_frz_q, receiver_powerdown_prev_q;
  logic [6:0]           settle_lim;
  always_comb begin
    case (avg_q.settling)
      2'b00:   settle_lim = RFB_SETTLE_0;
      2'b01:   settle_lim = RFB_SETTLE_1;
      2'b10:   settle_lim = RFB_SETTLE_2;
      default: settle_lim = RFB_SETTLE_3;
    endcase
  end
  wire rx_on   = !ctrl_q.receiver_powerdown;
  wire rx_enter = rx_on && receiver_powerdown_prev_q;
  wire frozen  = avg_q.select ? avg_q.manual : auto_frz_q;
  wire [RFB_AVG_W:0] avg_sum = {1'b0, avg_val_q} + {1'b0, dfil_q};
  wire slice_bit = dfil_q > avg_val_q;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      avg_val_q    <= '0;
      settle_cnt_q <= '0;
      auto_frz_q   <= 1'b0;
      receiver_powerdown_prev_q <= 1'b1;
    end else if (mdm_clr) begin
      avg_val_q    <= '0;
      settle_cnt_q <= '0;
      auto_frz_q   <= 1'b0;
      receiver_powerdown_prev_q <= 1'b1;
    end else begin
      receiver_powerdown_prev_q <= ctrl_q.receiver_powerdown;
      if (rx_enter) begin
        settle_cnt_q <= '0;
        auto_frz_q   <= 1'b0;
      end else if (rx_on && !auto_frz_q && baud_tick) begin
        settle_cnt_q <= settle_cnt_q + 7'd1;
        if (settle_cnt_q + 7'd1 >= settle_lim) auto_frz_q <= 1'b1;
      end
      // only updated while receiving and not frozen, so power-down keeps it
      if (rx_on && !frozen)
        avg_val_q <= avg_sum[RFB_AVG_W:1];
    end
  end

  // shift register for both directions
  logic [DATA_W-1:0] sh_q;
  logic [3:0]        sh_cnt_q;
  logic              tx_q, rxb_q, transmitter_powerdown_prev_q;
  wire tx_on   = !ctrl_q.transmitter_powerdown;
  wire tx_up   = tx_on && transmitter_powerdown_prev_q;
  wire [3:0] sh_len = ctrl_q.bytemode ? 4'd8 : 4'd1;
  wire tx_load = tx_on && (tx_up || (bit_tick && sh_cnt_q == 4'd1));
  wire rx_full = rx_on && !tx_on && bit_tick && sh_cnt_q == sh_len - 4'd1;
  wire buf_evt = tx_load || rx_full;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      sh_q         <= '0;
      sh_cnt_q     <= '0;
      tx_q         <= 1'b0;
      transmitter_powerdown_prev_q <= 1'b1;
      rxb_q        <= 1'b0;
    end else if (mdm_clr) begin
      sh_q         <= '0;
      sh_cnt_q     <= '0;
      tx_q         <= 1'b0;
      transmitter_powerdown_prev_q <= 1'b1;
      rxb_q        <= 1'b0;
    end else begin
      transmitter_powerdown_prev_q <= ctrl_q.transmitter_powerdown;
      rxb_q        <= slice_bit;
      if (tx_load) begin
        // byte mode loads the whole buffer, bit mode only bit 0
        sh_q     <= ctrl_q.bytemode ? buf_q : {buf_q[0], {(DATA_W-1){1'b0}}};
        sh_cnt_q <= sh_len;
        tx_q     <= ctrl_q.bytemode ? buf_q[DATA_W-1] : buf_q[0];
      end else if (tx_on && bit_tick) begin
        sh_q     <= {sh_q[DATA_W-2:0], 1'b0};
        sh_cnt_q <= sh_cnt_q - 4'd1;
        tx_q     <= sh_q[DATA_W-2];
      end else if (rx_on && !tx_on && bit_tick) begin
        sh_q     <= {sh_q[DATA_W-2:0], slice_bit};
        sh_cnt_q <= rx_full ? 4'd0 : sh_cnt_q + 4'd1;
      end
    end
  end

  // register writes and hardware buffer updates
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= RFB_CTRL_RST;
      avg_q      <= RFB_AVG_RST;
      buf_q      <= '0;
      baud_div_q <= RFB_BAUD_RST;
      irq_q      <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= wdata_q[4:0];
      if (wr_avg)  avg_q  <= wdata_q[3:0];
      if (wr_baud) baud_div_q <= wdata_q[15:0];
      // a received unit overwrites whatever software has not read yet
      if (rx_full) begin
        buf_q <= ctrl_q.bytemode ? {sh_q[DATA_W-2:0], slice_bit}
                                 : {{(DATA_W-1){1'b0}}, sh_q[0]};
      end else if (wr_data) begin
        buf_q <= wdata_q[DATA_W-1:0];
      end
      // hardware set wins over a software clear in the same cycle
      if (buf_evt)
        irq_q <= 1'b1;
      else if (wr_stat && wdata_q[RFB_STAT_IRQ])
        irq_q <= 1'b0;
    end
  end

  // read channel
  logic        rvalid_q;
  logic        arready_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  // one read in flight: ready drops on a take and returns when the answer leaves
  wire ar_take = s_axi_arvalid_in && arready_q;
  wire [31:0] stat_word = {30'h0, frozen, irq_q};
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr_in)
      RFB_ADDR_DATA: rd_mux = {{(32-DATA_W){1'b0}}, buf_q};
      RFB_ADDR_CTRL: rd_mux = {27'h0, ctrl_q};
      RFB_ADDR_AVG:  rd_mux = {28'h0, avg_q};
      RFB_ADDR_STAT: rd_mux = stat_word;
      RFB_ADDR_BAUD: rd_mux = {16'h0, baud_div_q};
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RFB_RESP_OKAY;
    end else begin
      arready_q <= !(ar_take || (rvalid_q && !s_axi_rready_in));
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_hit ? RFB_RESP_OKAY : RFB_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready_in) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // every bus output comes straight from a register
  assign s_axi_awready_out  = awready_q;
  assign s_axi_wready_out   = wready_q;
  assign s_axi_bvalid_out   = bvalid_q;
  assign s_axi_bresp_out    = bresp_q;
  assign s_axi_arready_out  = arready_q;
  assign s_axi_rvalid_out   = rvalid_q;
  assign s_axi_rdata_out    = rdata_q;
  assign s_axi_rresp_out    = rresp_q;
  assign tx_bit_out         = tx_q;
  assign radio_irq_flag_out = irq_q;
  assign rx_bit_out         = rxb_q;
endmodule
`default_nettype wire

// ---- bench/rfb_top_sva.sv ----
// checker for rfb_top: bus answers, read error replies, sticky flag, reset state
// assumes it is bound to rfb_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module rfb_top_sva
  import rfb_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        rstn_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        radio_irq_flag_out
);
  logic ar_take;
  logic ar_known;
  assign ar_take  = s_axi_arvalid_in && s_axi_arready_out;
  assign ar_known = s_axi_araddr_in inside {RFB_ADDR_DATA, RFB_ADDR_CTRL, RFB_ADDR_AVG,
                                            RFB_ADDR_STAT, RFB_ADDR_BAUD};
  default clocking dcb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  a_bvalid_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
  a_rvalid_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer dropped");
  a_wr_answer: assert property (s_axi_awvalid_in && s_axi_awready_out |->
    ##[1:6] s_axi_bvalid_out) else $error("write answer missing");
  a_rd_answer: assert property (ar_take |-> ##[1:3] s_axi_rvalid_out)
    else $error("read answer missing");
  a_rd_unknown: assert property (ar_take && !ar_known |-> ##[1:3] (s_axi_rvalid_out &&
    s_axi_rresp_out == RFB_RESP_SLVERR && s_axi_rdata_out == 32'h0)) else $error("bad refusal");
  a_rd_known: assert property (ar_take && ar_known |-> ##[1:3] (s_axi_rvalid_out &&
    s_axi_rresp_out == RFB_RESP_OKAY)) else $error("mapped read refused");
  a_irq_clear: assert property ($fell(radio_irq_flag_out) |->
    $past(s_axi_wvalid_in) || $past(s_axi_wvalid_in, 2) || $past(s_axi_wvalid_in, 3))
    else $error("flag cleared without a write");
  a_reset_quiet: assert property ($rose(rstn_in) |-> !radio_irq_flag_out &&
    !s_axi_bvalid_out && !s_axi_rvalid_out) else $error("outputs busy after reset");
endmodule

bind rfb_top rfb_top_sva i_sva (
  .mclk_in, .rstn_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .radio_irq_flag_out
);
`default_nettype wire

// ---- bench/rfb_radio_model.sv ----
// radio model: alternating or steady demodulator levels, captures transmitted bits
// assumes one bit per BAUD_CLKS clocks, matching the baud register the bench writes
`timescale 1ns/100ps
`default_nettype none
module rfb_radio_model
  import rfb_pkg::*;
#(
  parameter int BAUD_CLKS = 4
) (
  input  wire logic             mclk_in,
  input  wire logic             rstn_in,
  input  wire logic             tx_bit_in,
  input  wire logic [1:0]       mode_in,
  output logic [RFB_AVG_W-1:0]  data_filter_out,
  output logic [7:0]            tx_shift_out
);
  int   cnt_q;
  logic phase_q;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q        <= 0;
      phase_q      <= 1'h0;
      tx_shift_out <= 8'h00;
    end else if (cnt_q == BAUD_CLKS - 1) begin
      cnt_q        <= 0;
      phase_q      <= ~phase_q;
      tx_shift_out <= {tx_shift_out[6:0], tx_bit_in};
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
  // alternating levels keep the average centred; steady levels probe the slicer
  // the peak remover is not modelled; its threshold is software's business
  assign data_filter_out = (mode_in == 2'h0) ? {RFB_AVG_W{phase_q}} :
                           {RFB_AVG_W{mode_in == 2'h1}};
endmodule
`default_nettype wire

// ---- bench/rf_data_buffer_and_slicer_lock_test.sv ----
// bench for the rf data buffer: register, transmit, receive and freeze sequences
// assumes rfb_top, the radio model and the bound checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module rf_data_buffer_and_slicer_lock_test;
  import rfb_pkg::*;
  logic mclk_in = 1'h0, rstn_in = 1'h0;
  logic [11:0] s_axi_awaddr_in = 12'h0, s_axi_araddr_in = 12'h0;
  logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
  logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0, hit;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, tx_bit_out, radio_irq_flag_out, rx_bit_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, mode = 2'h0;
  logic [RFB_AVG_W-1:0] data_filter_in;
  logic [7:0] tx_seen;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  int settle[4] = '{11, 22, 43, 86};

  rfb_top i_dut (.mclk_in, .rstn_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .data_filter_in, .tx_bit_out, .radio_irq_flag_out, .rx_bit_out);
  rfb_radio_model #(.BAUD_CLKS(4)) i_radio (.mclk_in, .rstn_in, .tx_bit_in(tx_bit_out),
    .mode_in(mode), .data_filter_out(data_filter_in), .tx_shift_out(tx_seen));

  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  // lag holds the answer's ready low for a few cycles to exercise a stalled master
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] er = RFB_RESP_OKAY, input int lag = 0);
    int n = 0;
    @(posedge mclk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= (lag == 0);
    forever begin
      @(posedge mclk_in);
      n++;
      if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
      if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
      if (s_axi_bvalid_out && s_axi_bready_in) break;
      if (n == lag) s_axi_bready_in <= 1'h1;
    end
    s_axi_bready_in <= 1'h0;
    chk_word({30'h0, s_axi_bresp_out}, {30'h0, er});
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input logic [1:0] er = RFB_RESP_OKAY, input int lag = 0);
    int n = 0;
    @(posedge mclk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= (lag == 0);
    forever begin
      @(posedge mclk_in);
      n++;
      if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
      if (s_axi_rvalid_out && s_axi_rready_in) break;
      if (n == lag) s_axi_rready_in <= 1'h1;
    end
    s_axi_rready_in <= 1'h0;
    chk_word(s_axi_rdata_out, exp);
    chk_word({30'h0, s_axi_rresp_out}, {30'h0, er});
  endtask

  initial begin
    repeat (8) @(posedge mclk_in);
    rstn_in <= 1'h1;
    repeat (4) @(posedge mclk_in);
    rd_chk(RFB_ADDR_DATA, 32'h0);
    rd_chk(RFB_ADDR_CTRL, 32'h16);
    rd_chk(RFB_ADDR_AVG, 32'he);
    rd_chk(RFB_ADDR_STAT, 32'h0);
    rd_chk(RFB_ADDR_BAUD, 32'h10);
    rd_chk(12'h010, 32'h0, RFB_RESP_SLVERR, 3);
    axi_wr(12'h014, 32'h1, RFB_RESP_SLVERR, 3);
    axi_wr(RFB_ADDR_BAUD, 32'h3);
    axi_wr(RFB_ADDR_DATA, 32'ha5);
    axi_wr(RFB_ADDR_CTRL, 32'h15);
    hit = 1'h0;
    repeat (200) begin
      @(posedge mclk_in);
      hit |= (tx_seen == 8'ha5);
    end
    chk_bit(hit, 1'h1);
    chk_bit(radio_irq_flag_out, 1'h1);
    rd_chk(RFB_ADDR_DATA, 32'ha5);
    axi_wr(RFB_ADDR_CTRL, 32'h14);
    // a byte may still be draining from the shifter, so allow a full byte first
    for (int b = 1; b >= 0; b--) begin
      axi_wr(RFB_ADDR_DATA, 32'(b));
      repeat (40) @(posedge mclk_in);
      chk_bit(tx_bit_out, b[0]);
    end
    axi_wr(RFB_ADDR_CTRL, 32'h16);
    axi_wr(RFB_ADDR_STAT, 32'h1, RFB_RESP_OKAY, 2);
    chk_bit(radio_irq_flag_out, 1'h0);
    foreach (settle[i]) begin
      axi_wr(RFB_ADDR_CTRL, 32'h06);
      axi_wr(RFB_ADDR_CTRL, 32'h16);
      axi_wr(RFB_ADDR_STAT, 32'h1);
      rd_chk(RFB_ADDR_STAT, 32'h0);
      axi_wr(RFB_ADDR_AVG, 32'(i << 2));
      // odd passes receive in manchester with the manual bit left at zero
      axi_wr(RFB_ADDR_CTRL, i[0] ? 32'h1a : 32'h12);
      repeat (settle[i] * 4 - 16) @(posedge mclk_in);
      rd_chk(RFB_ADDR_STAT, 32'h1);
      repeat (24) @(posedge mclk_in);
      rd_chk(RFB_ADDR_STAT, 32'h3);
      axi_wr(RFB_ADDR_CTRL, 32'h16);
      rd_chk(RFB_ADDR_STAT, 32'h3);
    end
    axi_wr(RFB_ADDR_CTRL, 32'h06);
    axi_wr(RFB_ADDR_STAT, 32'h1);
    axi_wr(RFB_ADDR_AVG, 32'h2);
    axi_wr(RFB_ADDR_CTRL, 32'h13);
    repeat (200) @(posedge mclk_in);
    axi_wr(RFB_ADDR_AVG, 32'h3);
    rd_chk(RFB_ADDR_STAT, 32'h3);
    for (int m = 1; m <= 2; m++) begin
      mode <= 2'(m);
      repeat (100) @(posedge mclk_in);
      chk_bit(rx_bit_out, m == 1);
    end
    close_out();
  end
endmodule
`default_nettype wire
